/* common/scpt_pkg.sv */
// Package for the serial configuration and phase table block.
// Assumes a single 20 MHz system clock domain; serial pins are asynchronous.
package scpt_pkg;

  // ---------------------------------------------------------------------------
  // Word layout and register selection
  // ---------------------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam logic [4:0] WORD_EDGES = 5'h10;
  localparam logic [1:0] SEL_SYS_CFG_ZERO = 2'h0;
  localparam logic [1:0] SEL_SYS_CFG_ONE = 2'h1;
  localparam logic [1:0] SEL_TABLE = 2'h3;
  localparam logic [15:0] SYS_CFG_ZERO_RESET = 16'h271C;
  localparam logic [4:0] TABLE_LAST = 5'h0F;
  localparam logic [4:0] TABLE_DONE = 5'h10;
  localparam int TABLE_COPIES = 8;

  // ---------------------------------------------------------------------------
  // Timing constants
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Decoded times are reported in quarter microseconds (ticks of a 4 MHz clock).
  localparam int TICK_PER_US = 4;

  // Decoded configuration 0 fields.
  typedef struct packed {
    logic       syncRect;
    logic [1:0] microstepSelect;
    logic [1:0] maxCurrentSelect;
    logic [2:0] fastDecayTime;
    logic [1:0] blankingTime;
    logic [2:0] offTimeSelect;
    logic       fixedFreq;
  } scpt_cfg0_t;

  // Decoded values for the regulator, times in 4 MHz ticks.
  typedef struct packed {
    logic [4:0] stepsPerFull;
    logic [6:0] currentPct;
    logic [7:0] fastDecayTicks;
    logic [3:0] blankTicks;
    logic [7:0] offTicks;
    logic [7:0] periodTicks;
  } scpt_dec_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } scpt_state_t;

endpackage : scpt_pkg

/* hdl/scpt_serial_config.sv */
// Serial configuration port with phase table loader, fault registers and
// configuration 0 decode. Assumes an external master drives the select,
// clock and data pins; all of them are synchronised here before use.
`timescale 1ns/10ps
`default_nettype none
module scpt_serial_config
  import scpt_pkg::*;
(
  // System
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial pins
  input  wire logic       serialSelectLow,
  input  wire logic       serialClk,
  input  wire logic       serialDataIn,
  output logic            serialDataOut,
  output logic            serialDataOutEn,
  // External reset pin
  input  wire logic       externalResetLow,
  // Fault inputs from the drive, bits 14..0 of fault register zero
  input  wire logic [14:0] faultIn,
  // Table read port
  input  wire logic [6:0] tableReadAddr,
  input  wire logic       tableReadPhaseB,
  output logic [5:0]      tableReadData,
  // Configuration outputs
  output scpt_cfg0_t      cfg0,
  output scpt_dec_t       cfgDecoded,
  output logic            summaryFaultFlag
);

  // ---------------------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] sync1Q, sync2Q;
  logic       sckPrevQ;
  logic       selLow, sck, sdi, extRstLow;

  // Two stages for each pin; only the second stage is used by logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1Q <= 4'hF;
      sync2Q <= 4'hF;
    end else begin
      sync1Q <= {externalResetLow, serialDataIn, serialClk, serialSelectLow};
      sync2Q <= sync1Q;
    end
  end
  assign selLow    = sync2Q[0];
  assign sck       = sync2Q[1];
  assign sdi       = sync2Q[2];
  assign extRstLow = sync2Q[3];

  // Previous clock level for rising edge detection.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sckPrevQ <= 1'b1;
    else     sckPrevQ <= sck;
  end

  logic sckRise;
  assign sckRise = sck & ~sckPrevQ & ~selLow ? 1'b1 : 1'b0;

  // ---------------------------------------------------------------------------
  // Serial shift engine
  // ---------------------------------------------------------------------------
  scpt_state_t stateQ;
  logic [15:0] shiftQ;
  logic [4:0]  edgeCntQ;
  logic        frameEnd, goodWord, badWord;

  assign frameEnd = (stateQ == ST_SHIFT) && selLow;
  assign goodWord = frameEnd && (edgeCntQ == WORD_EDGES);
  assign badWord  = frameEnd && (edgeCntQ != WORD_EDGES);

  // Frame state: idle, shifting while select is low, done for one cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateQ <= ST_IDLE;
    end else begin
      case (stateQ)
        ST_IDLE:  if (!selLow) stateQ <= ST_SHIFT;
        ST_SHIFT: if (selLow) stateQ <= ST_DONE;
        ST_DONE:  stateQ <= ST_IDLE;
        default:  stateQ <= ST_IDLE;
      endcase
    end
  end

  // Shift in MSB first; the counter saturates so extra edges stay an error.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftQ   <= 16'h0000;
      edgeCntQ <= 5'h00;
    end else if (stateQ == ST_IDLE) begin
      edgeCntQ <= 5'h00;
    end else if (sckRise) begin
      shiftQ <= {shiftQ[14:0], sdi};
      if (edgeCntQ != 5'h1F) edgeCntQ <= edgeCntQ + 5'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Resets: power-on is rst; long external pulse is counted here.
  // ---------------------------------------------------------------------------
  logic [7:0] extCntQ;
  logic       extReset;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)            extCntQ <= 8'h00;
    else if (extRstLow) extCntQ <= 8'h00;
    else if (extCntQ != 8'hFF) extCntQ <= extCntQ + 8'h01;
  end
  // Held one cycle per pulse so a stuck-low pin does not re-fire endlessly.
  assign extReset = (extCntQ == 8'(RESET_PULSE_CYC));

  // ---------------------------------------------------------------------------
  // Phase table loader
  // ---------------------------------------------------------------------------
  logic       tableWrite, otherWrite, parityBad;
  logic [4:0] ptrQ;
  logic [5:0] tableQ [16];

  assign tableWrite = goodWord && (shiftQ[15:14] == SEL_TABLE);
  assign otherWrite = goodWord && (shiftQ[15:14] != SEL_TABLE);
  assign parityBad  = tableWrite && ~(^shiftQ[6:0]);

  // Pointer returns to zero on reset, other writes and transfer errors.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ptrQ <= 5'h00;
    else if (extReset || otherWrite || badWord) ptrQ <= 5'h00;
    else if (tableWrite && ptrQ != TABLE_DONE) ptrQ <= ptrQ + 5'h01;
  end

  // Only power-on restores the default ramp; bad parity still stores.
  for (genvar i = 0; i < 16; i++) begin : g_table
    always_ff @(posedge clk or posedge rst) begin
      if (rst) tableQ[i] <= 6'(4 * i + 3);
      else if (tableWrite && ptrQ == 5'(i)) tableQ[i] <= shiftQ[5:0];
    end
  end

  // Mirror one quadrant into all four quadrants of the 64-step table.
  logic [5:0] stepA;
  logic [5:0] qIdx;
  logic       zeroStep;
  always_comb begin
    stepA = tableReadPhaseB ? 6'(tableReadAddr[5:0] + 6'h30) : tableReadAddr[5:0];
    qIdx  = stepA[4] ? 6'(6'h10 - {2'h0, stepA[3:0]}) : {2'h0, stepA[3:0]};
    zeroStep = (stepA[4:0] == 5'h00);
    if (zeroStep)      tableReadData = 6'h00;
    else if (qIdx == 6'h10) tableReadData = tableQ[15];
    else               tableReadData = tableQ[qIdx[3:0] - 4'h1];
  end

  // ---------------------------------------------------------------------------
  // Fault registers
  // ---------------------------------------------------------------------------
  logic [14:0] fault0Q;
  logic        errQ;
  // Hardware sets win over the clear in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault0Q <= 15'h7FFF;
      errQ    <= 1'b1;
    end else begin
      if (goodWord || extReset) fault0Q <= faultIn;
      else                      fault0Q <= fault0Q | faultIn;
      if (badWord || parityBad) errQ <= 1'b1;
      else if (goodWord || extReset) errQ <= 1'b0;
    end
  end
  assign summaryFaultFlag = errQ | (|fault0Q);

  // Serial output shows the summary flag, then shifts diagnostics MSB first.
  logic [15:0] outShiftQ;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) outShiftQ <= 16'h0000;
    else if (stateQ == ST_IDLE) outShiftQ <= {summaryFaultFlag, fault0Q};
    else if (sckRise) outShiftQ <= {outShiftQ[14:0], 1'b0};
  end
  assign serialDataOut   = outShiftQ[15];
  assign serialDataOutEn = ~selLow;

  // ---------------------------------------------------------------------------
  // Configuration register 0 and decode
  // ---------------------------------------------------------------------------
  logic [13:0] cfg0Q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cfg0Q <= SYS_CFG_ZERO_RESET[13:0];
    else if (extReset) cfg0Q <= SYS_CFG_ZERO_RESET[13:0];
    else if (goodWord && shiftQ[15:14] == SEL_SYS_CFG_ZERO) cfg0Q <= shiftQ[13:0];
  end
  assign cfg0 = scpt_cfg0_t'(cfg0Q);

  // Lookup of the field codes; times are 4 MHz ticks.
  always_comb begin
    cfgDecoded = '0;
    case (cfg0.microstepSelect)
      2'h0: cfgDecoded.stepsPerFull = 5'h01;
      2'h1: cfgDecoded.stepsPerFull = 5'h02;
      2'h2: cfgDecoded.stepsPerFull = 5'h04;
      default: cfgDecoded.stepsPerFull = 5'h10;
    endcase
    cfgDecoded.currentPct = 7'(25 * ({5'h00, cfg0.maxCurrentSelect} + 7'h01));
    case (cfg0.fastDecayTime)
      3'h0: cfgDecoded.fastDecayTicks = 8'h08;
      3'h1: cfgDecoded.fastDecayTicks = 8'h0C;
      3'h2: cfgDecoded.fastDecayTicks = 8'h10;
      3'h3: cfgDecoded.fastDecayTicks = 8'h18;
      3'h4: cfgDecoded.fastDecayTicks = 8'h20;
      3'h5: cfgDecoded.fastDecayTicks = 8'h28;
      3'h6: cfgDecoded.fastDecayTicks = 8'h38;
      default: cfgDecoded.fastDecayTicks = 8'h50;
    endcase
    case (cfg0.blankingTime)
      2'h0: cfgDecoded.blankTicks = 4'h4;
      2'h1: cfgDecoded.blankTicks = 4'h6;
      2'h2: cfgDecoded.blankTicks = 4'hA;
      default: cfgDecoded.blankTicks = 4'hE;
    endcase
    if (!cfg0.fixedFreq)
      cfgDecoded.offTicks = 8'(TICK_PER_US * (20 + 4 * int'(cfg0.offTimeSelect)));
    case (cfg0.offTimeSelect)
      3'h0: cfgDecoded.periodTicks = 8'h60;
      3'h1: cfgDecoded.periodTicks = 8'h80;
      3'h2: cfgDecoded.periodTicks = 8'hA0;
      3'h3: cfgDecoded.periodTicks = 8'hB8;
      3'h4: cfgDecoded.periodTicks = 8'hD0;
      3'h5: cfgDecoded.periodTicks = 8'hE0;
      3'h6: cfgDecoded.periodTicks = 8'hF0;
      default: cfgDecoded.periodTicks = 8'hFF;
    endcase
    if (!cfg0.fixedFreq) cfgDecoded.periodTicks = 8'h00;
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_route_table;
    @(posedge clk) disable iff (rst) tableWrite && !extReset |=> $stable(cfg0Q);
  endproperty
  a_route_table: assert property (p_route_table) else $error("table route bad");

  property p_ptr_adv;
    @(posedge clk) disable iff (rst)
      tableWrite && ptrQ < TABLE_DONE && !extReset |=> ptrQ == $past(ptrQ) + 5'h01;
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");

  property p_ptr_hold;
    @(posedge clk) disable iff (rst)
      tableWrite && ptrQ == TABLE_DONE && !extReset |=> ptrQ == TABLE_DONE;
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("full table moved");

  property p_ptr_clear;
    @(posedge clk) disable iff (rst) (otherWrite || badWord) |=> ptrQ == 5'h00;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");

  property p_parity;
    @(posedge clk) disable iff (rst) parityBad |=> errQ && summaryFaultFlag;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag missing");

  property p_store;
    @(posedge clk) disable iff (rst)
      tableWrite && ptrQ < TABLE_DONE && !extReset |=> tableQ[$past(ptrQ[3:0])] == $past(shiftQ[5:0]);
  endproperty
  a_store: assert property (p_store) else $error("value not stored");

  property p_clear;
    @(posedge clk) disable iff (rst)
      goodWord && !parityBad |=> !errQ && fault0Q == $past(faultIn);
  endproperty
  a_clear: assert property (p_clear) else $error("faults not cleared");

  property p_err;
    @(posedge clk) disable iff (rst) badWord && !extReset |=> errQ && $stable(cfg0Q);
  endproperty
  a_err: assert property (p_err) else $error("transfer error mishandled");

  property p_summary;
    @(posedge clk) disable iff (rst) (badWord || parityBad || (|faultIn)) |=> summaryFaultFlag;
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag low");

  c_table: cover property (@(posedge clk) disable iff (rst) tableWrite ##[1:300] tableWrite);
  c_full: cover property (@(posedge clk) disable iff (rst) ptrQ == TABLE_DONE);
  c_cfg: cover property (@(posedge clk) disable iff (rst) otherWrite);
  c_bad: cover property (@(posedge clk) disable iff (rst) badWord);

endmodule : scpt_serial_config
`default_nettype wire

/* tb/scpt_ctrl_model.sv */
// Controller model that plays the serial master of the configuration port.
// Assumes a 20 MHz bench clock and drives a 400 ns serial clock.
`timescale 1ns/10ps
`default_nettype none
module scpt_ctrl_model (
  // Serial pins
  output logic     serialSelectLow,
  output logic     serialClk,
  output logic     serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn
);
  // Enable and data seen before the first clock rise of a frame.
  logic [1:0] firstOut;

  initial begin
    serialSelectLow = 1'b1;
    serialClk = 1'b1;
    serialDataIn = 1'b0;
    firstOut = 2'h0;
  end

  // Sends one frame MSB first; the clock stands high outside frames.
  task automatic sendWord(input logic [15:0] word, input int edges);
    logic [15:0] sh;
    sh = word;
    serialSelectLow = 1'b0;
    #600;
    firstOut = {serialDataOutEn, serialDataOut};
    for (int i = 0; i < edges; i++) begin
      serialClk = 1'b0;
      serialDataIn = sh[15];
      #200;
      serialClk = 1'b1;
      #200;
      sh = {sh[14:0], ~sh[15]};
    end
    serialSelectLow = 1'b1;
    #400;
    // A released data line must not keep showing the last bit.
    serialDataIn = ~serialDataIn;
    #400;
  endtask : sendWord
endmodule : scpt_ctrl_model
`default_nettype wire

/* tb/scpt_serial_config_tb.sv */
// Self-checking bench for the serial configuration and phase table block.
// Assumes the controller model drives the serial pins of the port.
`timescale 1ns/10ps
`default_nettype none
module scpt_serial_config_tb
  import scpt_pkg::*;
;
  // ----
  // Signals
  // ----
  logic        clk, rst, extRstLow, phaseB, selLow, sclk, sdi, sdo, sdoEn, flag;
  logic [14:0] faultIn;
  logic [6:0]  rdAddr;
  logic [5:0]  rdData;
  logic [15:0] w;
  scpt_cfg0_t  cfg0;
  scpt_dec_t   dec;
  int          numErrors, compares;
  // Expected decodes, indexed by field code.
  logic [4:0] stepsTab [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
  logic [6:0] pctTab [4] = '{7'h19, 7'h32, 7'h4B, 7'h64};
  logic [3:0] bkTab [4] = '{4'h4, 4'h6, 4'hA, 4'hE};
  logic [7:0] fdTab [8] = '{8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h28, 8'h38, 8'h50};
  logic [7:0] perTab [8] = '{8'h60, 8'h80, 8'hA0, 8'hB8, 8'hD0, 8'hE0, 8'hF0, 8'hFF};

  scpt_serial_config dut (.clk(clk), .rst(rst), .serialSelectLow(selLow), .serialClk(sclk),
    .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOutEn(sdoEn),
    .externalResetLow(extRstLow), .faultIn(faultIn), .tableReadAddr(rdAddr),
    .tableReadPhaseB(phaseB), .tableReadData(rdData), .cfg0(cfg0), .cfgDecoded(dec),
    .summaryFaultFlag(flag));
  scpt_ctrl_model master (.serialSelectLow(selLow), .serialClk(sclk), .serialDataIn(sdi),
    .serialDataOut(sdo), .serialDataOutEn(sdoEn));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic send(input logic [15:0] word, input int edges);
    @(posedge clk);
    #1;
    master.sendWord(word, edges);
  endtask : send

  // Table word with a good or a deliberately wrong odd parity bit.
  function automatic logic [15:0] tblWord(input logic [5:0] v, input logic good);
    return {2'b11, 7'h00, good ? ~^v : ^v, v};
  endfunction : tblWord

  // Reads four mirrored places of one entry, both phases (entries 0 to 14 have eight, entry 15 has only these four).
  task automatic checkPt(input int j, input logic [5:0] exp);
    logic [6:0] loc [4];
    loc = '{7'(j + 1), 7'(63 - j), 7'(15 - j), 7'(17 + j)};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #1;
      rdAddr = loc[k];
      phaseB = (k >= 2);
      #5;
      check(rdData, exp);
    end
  endtask : checkPt

  task automatic checkDecode(input logic [2:0] k, input logic pwm);
    check(dec.stepsPerFull, stepsTab[k[1:0]]);
    check(dec.currentPct, pctTab[k[1:0]]);
    check(dec.fastDecayTicks, fdTab[k]);
    check(dec.blankTicks, bkTab[k[1:0]]);
    if (pwm) check(dec.periodTicks, perTab[k]);
    else check(dec.offTicks, 8'(8'h50 + 8'h10 * k));
  endtask : checkDecode

  // Hang guard; it ends the run through the same closing report.
  initial begin
    repeat (100000) @(posedge clk);
    numErrors++;
    stop_test();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rst = 1'b1;
    extRstLow = 1'b1;
    faultIn = 15'h0000;
    rdAddr = 7'h00;
    phaseB = 1'b0;
    numErrors = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(cfg0, SYS_CFG_ZERO_RESET[13:0]);
    check(flag, 1'b1);
    check(dec.stepsPerFull, 5'h01);
    check(dec.offTicks, 8'hB0);
    // Every field code, both timing modes.
    for (int i = 0; i < 16; i++) begin
      w = {2'b00, i[0], i[1:0], i[1:0], i[2:0], i[1:0], i[2:0], i[3]};
      send(w, 16);
      check(cfg0, w[13:0]);
      checkDecode(i[2:0], i[3]);
    end
    check(flag, 1'b0);
    // Short and long frames are abandoned and flagged.
    for (int e = 15; e <= 17; e += 2) begin
      send(16'h0000, e);
      check(cfg0, w[13:0]);
      check(flag, 1'b1);
      // A good word in between so that each error frame must raise the flag anew.
      send(w, 16);
      check(flag, 1'b0);
    end
    send(w, 16);
    // Full table load, one bad parity value, then one write too many.
    for (int j = 0; j < 17; j++) begin
      send(tblWord(6'(3 * j + 1), j != 5), 16);
      if (j == 5) check(flag, 1'b1);
      if (j == 6) check(master.firstOut, 2'h3);
      if (j == 6) check(flag, 1'b0);
    end
    for (int j = 0; j < 16; j++) checkPt(j, 6'(3 * j + 1));
    // Sequences broken by another register and by a transfer error.
    send(w, 16);
    for (int j = 0; j < 3; j++) send(tblWord(6'(6'h20 + j), 1'b1), 16);
    send(w, 16);
    send(tblWord(6'h2A, 1'b1), 16);
    checkPt(0, 6'h2A);
    checkPt(1, 6'h21);
    send(16'hC000, 15);
    send(tblWord(6'h15, 1'b1), 16);
    checkPt(0, 6'h15);
    // A live fault raises the summary flag; a long external reset clears it.
    @(posedge clk);
    #1;
    faultIn = 15'h4001;
    @(posedge clk);
    #1;
    faultIn = 15'h0000;
    repeat (3) @(posedge clk);
    check(flag, 1'b1);
    #1;
    extRstLow = 1'b0;
    repeat (RESET_PULSE_CYC + 5) @(posedge clk);
    #1;
    extRstLow = 1'b1;
    repeat (4) @(posedge clk);
    check(flag, 1'b0);
    check(cfg0, SYS_CFG_ZERO_RESET[13:0]);
    checkPt(0, 6'h15);
    send(tblWord(6'h3C, 1'b1), 16);
    checkPt(0, 6'h3C);
    // Power-on reset in mid-run restores the default ramp and the flag.
    @(posedge clk);
    #1;
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    check(flag, 1'b1);
    checkPt(0, 6'h03);
    stop_test();
  end
endmodule : scpt_serial_config_tb
`default_nettype wire
